// *** smr_cmd_resp.v ***
/*
  Command and response registers of a memory card host: command launch,
  argument words, response capture, CRC status token and first DMA kick.
  Assumes an AHB-Lite master on clk, a card on the command and data 0
  lines, and a data path that reports block ends and FIFO word requests.
*/
`timescale 1ns/1ps
`include "smr_defines.vh"

module smr_cmd_resp
#(
  parameter DIV_HALF = 4
)
(
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg card_clk,
  input wire cmd_in,
  output reg cmd_out,
  output reg cmd_oe_n,
  input wire dat0_in,
  input wire write_active,
  input wire fifo_word_req,
  input wire block_sent,
  output wire dma_req
);

  localparam CMD_IDLE = 2'd0;
  localparam CMD_SEND = 2'd1;
  localparam CMD_WAIT = 2'd2;
  localparam CMD_RECV = 2'd3;
  localparam TOK_IDLE = 2'd0;
  localparam TOK_HUNT = 2'd1;
  localparam TOK_RECV = 2'd2;

  reg wr_pend;
  reg [7:0] wr_addr;
  reg [15:0] arg_high;
  reg [15:0] arg_low;
  reg [7:0] rsp_index;
  reg [15:0] rsp_word [0:7];
  reg [7:0] crc_token;
  reg [1:0] fmt;
  reg [1:0] cmd_state;
  reg [7:0] bit_cnt;
  reg [7:0] rsp_len;
  reg [39:0] tx_sr;
  reg [135:0] rx_sr;
  reg [7:0] wait_cnt;
  reg [1:0] tok_state;
  reg [2:0] tok_cnt;
  reg [4:0] tok_sr;
  reg [3:0] status;
  reg tok_done;
  reg [7:0] div_cnt;
  reg cmd_meta;
  reg cmd_sync;
  reg dat_meta;
  reg dat_sync;
  reg dma_kick;
  reg dma_armed;
  wire tick;
  wire rise;
  wire fall;
  wire launch;
  wire [135:0] next_rx_sr;
  wire [7:0] rx_pos;
  wire rx_crc_bit;
  wire [6:0] tx_crc;
  wire [6:0] rx_crc;
  wire tx_crc_clear;
  wire tx_crc_update;
  wire tx_crc_shift;
  integer i;
  integer k;

  // Byte address of the word held in a response slot.
  function [7:0] rsp_ofs;
    input [2:0] idx;
    begin
      rsp_ofs = `SMR_OFS_RSP_BASE + {3'h0, idx, 2'b00};
    end
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign launch = wr_pend && (wr_addr == `SMR_OFS_LAUNCH);

  // AHB-Lite address phase; reads are answered in the following data phase.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend <= 1'b0;
      if (hsel && hready && htrans[1])
      begin
        wr_pend <= hwrite;
        wr_addr <= {haddr[7:2], 2'b00};
        hrdata <= 32'h00000000;
        if (!hwrite)
        begin
          if ({haddr[7:2], 2'b00} == `SMR_OFS_ARG_HIGH)
          begin
            hrdata <= {16'h0000, arg_high};
          end
          else if ({haddr[7:2], 2'b00} == `SMR_OFS_ARG_LOW)
          begin
            hrdata <= {16'h0000, arg_low};
          end
          else if ({haddr[7:2], 2'b00} == `SMR_OFS_RSP_INDEX)
          begin
            hrdata <= {24'h000000, rsp_index};
          end
          else if ({haddr[7:2], 2'b00} == `SMR_OFS_CRC_STATUS)
          begin
            hrdata <= {24'h000000, crc_token};
          end
          else if ({haddr[7:2], 2'b00} == `SMR_OFS_STATUS)
          begin
            hrdata <= {27'h0000000, tok_done, status};
          end
          else if ({haddr[7:2], 2'b00} == `SMR_OFS_LAUNCH)
          begin
            hrdata <= {21'h000000, fmt, 9'h000};
          end
          else
          begin
            for (k = 0; k < 8; k = k + 1)
            begin
              if ({haddr[7:2], 2'b00} == rsp_ofs(k[2:0]))
              begin
                hrdata <= {16'h0000, rsp_word[k]};
              end
            end
          end
        end
      end
    end
  end

  // Argument words are never touched by the sender, so they read back intact.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      arg_high <= `SMR_RESET_WORD;
      arg_low <= `SMR_RESET_WORD;
      fmt <= `SMR_FMT_NONE;
    end
    else if (wr_pend)
    begin
      if (wr_addr == `SMR_OFS_ARG_HIGH)
      begin
        arg_high <= hwdata[15:0];
      end
      else if (wr_addr == `SMR_OFS_ARG_LOW)
      begin
        arg_low <= hwdata[15:0];
      end
      else if (wr_addr == `SMR_OFS_LAUNCH)
      begin
        fmt <= hwdata[`SMR_FMT_MSB:`SMR_FMT_LSB];
      end
    end
  end

  // First DMA request comes from software, the rest from FIFO demand.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      dma_kick <= 1'b0;
      dma_armed <= 1'b0;
    end
    else
    begin
      dma_kick <= wr_pend && (wr_addr == `SMR_OFS_DMA_TRIG) && hwdata[0];
      if (!write_active)
      begin
        dma_armed <= 1'b0;
      end
      else if (dma_kick)
      begin
        dma_armed <= 1'b1;
      end
    end
  end

  assign dma_req = dma_kick || (dma_armed && fifo_word_req);

  // Card clock divider and pin synchronisers.
  assign tick = (div_cnt == DIV_HALF[7:0] - 8'd1);
  assign rise = tick && !card_clk;
  assign fall = tick && card_clk;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= 8'h00;
      card_clk <= 1'b0;
      cmd_meta <= 1'b1;
      cmd_sync <= 1'b1;
      dat_meta <= 1'b1;
      dat_sync <= 1'b1;
    end
    else
    begin
      div_cnt <= tick ? 8'h00 : div_cnt + 8'd1;
      if (tick)
      begin
        card_clk <= !card_clk;
      end
      cmd_meta <= cmd_in;
      cmd_sync <= cmd_meta;
      dat_meta <= dat0_in;
      dat_sync <= dat_meta;
    end
  end

  assign tx_crc_clear = launch;
  assign tx_crc_update = fall && (cmd_state == CMD_SEND) && (bit_cnt < `SMR_CMD_DATA_BITS);
  assign tx_crc_shift = fall && (cmd_state == CMD_SEND) && (bit_cnt >= `SMR_CMD_DATA_BITS);

  smr_crc7 u_tx_crc
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(tx_crc_clear),
    .update(tx_crc_update),
    .shift_out(tx_crc_shift),
    .bit_in(tx_sr[39]),
    .crc(tx_crc)
  );

  assign next_rx_sr = {rx_sr[134:0], cmd_sync};
  assign rx_pos = rsp_len - 8'd1 - bit_cnt;
  assign rx_crc_bit = (cmd_state == CMD_RECV) && rise && (rx_pos >= `SMR_RSP_CRC_LOW)
    && ((rsp_len == `SMR_RSP_SHORT) || (rx_pos <= `SMR_RSP_LONG_DATA_TOP));

  smr_crc7 u_rx_crc
  (
    .clk(clk),
    .rst_n(rst_n),
    .clear(launch),
    .update(rx_crc_bit),
    .shift_out(1'b0),
    .bit_in(cmd_sync),
    .crc(rx_crc)
  );

  // Command sender and response receiver.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_state <= CMD_IDLE;
      bit_cnt <= 8'h00;
      rsp_len <= 8'h00;
      tx_sr <= 40'h0000000000;
      rx_sr <= 136'h0;
      wait_cnt <= 8'h00;
      cmd_out <= 1'b1;
      cmd_oe_n <= 1'b1;
      rsp_index <= 8'h00;
      status[`SMR_ST_RSP_DONE:`SMR_ST_BUSY] <= 2'b00;
      status[`SMR_ST_CRC_ERR:`SMR_ST_TIMEOUT] <= 2'b00;
      for (i = 0; i < 8; i = i + 1)
      begin
        rsp_word[i] <= `SMR_RESET_WORD;
      end
    end
    else if (launch)
    begin
      cmd_state <= CMD_SEND;
      bit_cnt <= 8'h00;
      tx_sr <= {2'b01, hwdata[`SMR_CMD_INDEX_MSB:0], arg_high, arg_low};
      rsp_len <= (hwdata[`SMR_FMT_MSB:`SMR_FMT_LSB] == `SMR_FMT_136_CRC) ?
        `SMR_RSP_LONG : `SMR_RSP_SHORT;
      status[`SMR_ST_RSP_DONE:`SMR_ST_BUSY] <= 2'b01;
      status[`SMR_ST_CRC_ERR:`SMR_ST_TIMEOUT] <= 2'b00;
    end
    else
    begin
      case (cmd_state)
        CMD_SEND:
        begin
          if (fall)
          begin
            bit_cnt <= bit_cnt + 8'd1;
            cmd_oe_n <= 1'b0;
            if (bit_cnt < `SMR_CMD_DATA_BITS)
            begin
              cmd_out <= tx_sr[39];
              tx_sr <= {tx_sr[38:0], 1'b0};
            end
            else if (bit_cnt < `SMR_CMD_END_BIT)
            begin
              cmd_out <= tx_crc[6];
            end
            else if (bit_cnt == `SMR_CMD_END_BIT)
            begin
              cmd_out <= 1'b1;
            end
            else
            begin
              cmd_oe_n <= 1'b1;
              bit_cnt <= 8'h00;
              wait_cnt <= 8'h00;
              if (fmt == `SMR_FMT_NONE)
              begin
                cmd_state <= CMD_IDLE;
                status[`SMR_ST_BUSY] <= 1'b0;
              end
              else
              begin
                cmd_state <= CMD_WAIT;
              end
            end
          end
        end
        CMD_WAIT:
        begin
          if (rise)
          begin
            if (!cmd_sync)
            begin
              cmd_state <= CMD_RECV;
              rx_sr <= next_rx_sr;
              bit_cnt <= 8'd1;
            end
            else if (wait_cnt == `SMR_RSP_TIMEOUT - 8'd1)
            begin
              cmd_state <= CMD_IDLE;
              status[`SMR_ST_BUSY] <= 1'b0;
              status[`SMR_ST_TIMEOUT] <= 1'b1;
            end
            else
            begin
              wait_cnt <= wait_cnt + 8'd1;
            end
          end
        end
        CMD_RECV:
        begin
          if (rise)
          begin
            rx_sr <= next_rx_sr;
            bit_cnt <= bit_cnt + 8'd1;
            if (bit_cnt == rsp_len - 8'd1)
            begin
              cmd_state <= CMD_IDLE;
              status[`SMR_ST_BUSY] <= 1'b0;
              status[`SMR_ST_RSP_DONE] <= 1'b1;
              status[`SMR_ST_CRC_ERR] <= (fmt != `SMR_FMT_48_NOCRC)
                && (next_rx_sr[7:1] != rx_crc);
              if (rsp_len == `SMR_RSP_LONG)
              begin
                rsp_index <= next_rx_sr[135:128];
                for (i = 0; i < 8; i = i + 1)
                begin
                  rsp_word[i] <= next_rx_sr[i * 16 +: 16];
                end
              end
              else
              begin
                rsp_index <= next_rx_sr[47:40];
                rsp_word[7] <= next_rx_sr[39:24];
                rsp_word[6] <= next_rx_sr[23:8];
                rsp_word[5] <= {8'h00, next_rx_sr[7:0]};
              end
            end
          end
        end
        default:
        begin
          cmd_oe_n <= 1'b1;
          cmd_out <= 1'b1;
        end
      endcase
    end
  end

  // CRC status token: start bit, three status bits and end bit on data 0.
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      tok_state <= TOK_IDLE;
      tok_cnt <= 3'h0;
      tok_sr <= 5'h00;
      crc_token <= 8'h00;
      tok_done <= 1'b0;
    end
    else
    begin
      case (tok_state)
        TOK_IDLE:
        begin
          if (block_sent)
          begin
            tok_state <= TOK_HUNT;
          end
        end
        TOK_HUNT:
        begin
          if (rise && !dat_sync)
          begin
            tok_state <= TOK_RECV;
            tok_sr <= 5'h00;
            tok_cnt <= 3'h1;
          end
        end
        TOK_RECV:
        begin
          if (rise)
          begin
            tok_sr <= {tok_sr[3:0], dat_sync};
            tok_cnt <= tok_cnt + 3'h1;
            if (tok_cnt == `SMR_TOKEN_BITS - 3'h1)
            begin
              tok_state <= TOK_IDLE;
              crc_token <= {3'h0, tok_sr[3:0], dat_sync};
              tok_done <= 1'b1;
            end
          end
        end
        default:
        begin
          tok_state <= TOK_IDLE;
        end
      endcase
      if (wr_pend && (wr_addr == `SMR_OFS_CRC_STATUS) && !(tok_state == TOK_RECV && rise
        && tok_cnt == `SMR_TOKEN_BITS - 3'h1))
      begin
        crc_token <= hwdata[7:0];
        tok_done <= 1'b0;
      end
    end
  end

endmodule

// *** smr_defines.vh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  command and response register block. Assumes a 32-bit AHB-Lite slave
  port with each register in one aligned word.
*/
`ifndef SMR_DEFINES_VH
`define SMR_DEFINES_VH

`define SMR_OFS_LAUNCH 8'h00
`define SMR_OFS_DMA_TRIG 8'h04
`define SMR_OFS_ARG_HIGH 8'h08
`define SMR_OFS_ARG_LOW 8'h0c
`define SMR_OFS_RSP_INDEX 8'h10
`define SMR_OFS_CRC_STATUS 8'h14
`define SMR_OFS_STATUS 8'h18
`define SMR_OFS_RSP_BASE 8'h20
`define SMR_OFS_RSP_LAST 8'h3c

`define SMR_CMD_INDEX_MSB 5
`define SMR_FMT_MSB 10
`define SMR_FMT_LSB 9
`define SMR_FMT_NONE 2'h0
`define SMR_FMT_48_CRC 2'h1
`define SMR_FMT_136_CRC 2'h2
`define SMR_FMT_48_NOCRC 2'h3

`define SMR_RESET_WORD 16'h0000
`define SMR_CMD_DATA_BITS 8'd40
`define SMR_CMD_END_BIT 8'd47
`define SMR_CMD_BITS 8'd48
`define SMR_RSP_SHORT 8'd48
`define SMR_RSP_LONG 8'd136
`define SMR_RSP_CRC_LOW 8'd8
`define SMR_RSP_LONG_DATA_TOP 8'd127
`define SMR_TOKEN_BITS 3'd5
`define SMR_RSP_TIMEOUT 8'd64
`define SMR_CRC7_POLY 7'h09

`define SMR_ST_BUSY 0
`define SMR_ST_RSP_DONE 1
`define SMR_ST_TIMEOUT 2
`define SMR_ST_CRC_ERR 3
`define SMR_ST_TOKEN 4

`endif

// *** smr_crc7.v ***
/*
  Serial CRC7 generator for card command and response frames.
  Assumes the caller clears it before each frame and steps it once per bit.
*/
`timescale 1ns/1ps
`include "smr_defines.vh"

module smr_crc7
(
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire update,
  input wire shift_out,
  input wire bit_in,
  output reg [6:0] crc
);

  wire feedback;

  assign feedback = bit_in ^ crc[6];

  always @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      crc <= 7'h00;
    end
    else if (update)
    begin
      crc <= {crc[5:0], 1'b0} ^ (feedback ? `SMR_CRC7_POLY : 7'h00);
    end
    else if (shift_out)
    begin
      // Moves the finished checksum out most significant bit first.
      crc <= {crc[5:0], 1'b0};
    end
  end

endmodule

// *** smr_cmd_resp_asserts.sv ***
/* Checker for the command and response block.
   Assumes it is bound to every instance of smr_cmd_resp. */
`timescale 1ns/1ps
module smr_checker
#(
  parameter DIV_HALF = 4
)
(
  input wire clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire card_clk,
  input wire cmd_out,
  input wire cmd_oe_n,
  input wire write_active,
  input wire fifo_word_req,
  input wire dma_req
);
  localparam int LMAX = 4 * DIV_HALF + 4;
  reg ap_launch;
  reg ap_trig;
  reg armed;
  reg ck_d;
  reg [7:0] rises;
  wire take = hsel && hready && htrans[1] && hwrite;
  always @(posedge clk)
  begin
    ap_launch <= rst_n && take && (haddr[7:2] == 6'h00);
    ap_trig <= rst_n && take && (haddr[7:2] == 6'h01);
    armed <= rst_n && write_active && (armed || dma_req);
    ck_d <= card_clk;
    rises <= (!rst_n || cmd_oe_n) ? 8'h00 : rises + {7'h00, card_clk && !ck_d};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_launch_start:
    assert property (ap_launch |-> ##[1:LMAX] !cmd_oe_n) else $error("launch sent no frame");
  a_start_bit:
    assert property ($fell(cmd_oe_n) |-> !cmd_out) else $error("frame lacks start bit");
  a_idle_high:
    assert property (cmd_oe_n |-> cmd_out) else $error("idle line not high");
  a_frame_len:
    assert property ($rose(cmd_oe_n) |-> rises >= 8'd48 && rises <= 8'd49)
      else $error("frame length wrong");
  a_kick_once:
    assert property (ap_trig && hwdata[0] |-> ##[1:2] dma_req) else $error("no first request");
  a_kick_single:
    assert property (dma_req && !fifo_word_req |=> !dma_req || fifo_word_req)
      else $error("first request too long");
  a_zero_quiet:
    assert property (ap_trig && !hwdata[0] && !write_active |-> ##1 (!dma_req) [*3])
      else $error("request after zero write");
  a_dma_follow:
    assert property (armed && write_active && fifo_word_req |-> dma_req)
      else $error("later request missing");
  c_launch: cover property ($fell(cmd_oe_n));
  c_kick: cover property (dma_req && !fifo_word_req);
  c_follow: cover property (armed && fifo_word_req);
endmodule
bind smr_cmd_resp smr_checker #(.DIV_HALF(DIV_HALF)) smr_checker_i (.clk(clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .card_clk(card_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
  .write_active(write_active), .fifo_word_req(fifo_word_req), .dma_req(dma_req));

// *** smr_card.sv ***
/* Behavioural card on the command and data 0 lines.
   Assumes the host drives on card clock falls and samples on rises. */
`timescale 1ns/1ps
module smr_card
(
  input wire card_clk,
  input wire cmd_out,
  input wire cmd_oe_n,
  input wire [135:0] rsp,
  input wire [7:0] rsp_len,
  input wire [2:0] tok,
  input wire tok_go,
  output wire cmd_line,
  output reg dat0 = 1'b1,
  output reg [47:0] frame
);
  reg drv = 1'b1;
  integer n = 0;
  integer i;
  integer j;
  wire [4:0] tbits = {1'b0, tok, 1'b1};
  // The line is pulled up, so it reads high whenever nobody drives it.
  assign cmd_line = cmd_oe_n ? drv : cmd_out;
  initial
  begin
    frame = 48'h0;
    forever
    begin
      @(posedge card_clk);
      if (!cmd_oe_n)
      begin
        frame = {frame[46:0], cmd_out};
        n = n + 1;
      end
      if (n == 48)
      begin
        n = 0;
        repeat (3) @(negedge card_clk);
        for (i = rsp_len - 1; i >= 0; i = i - 1)
          @(negedge card_clk) drv = rsp[i];
        @(negedge card_clk) drv = 1'b1;
      end
    end
  end
  always @(posedge tok_go)
  begin
    for (j = 4; j >= 0; j = j - 1)
      @(negedge card_clk) dat0 = tbits[j];
  end
endmodule

// *** smr_cmd_resp_test.sv ***
/* Self-checking bench for the command and response block.
   Assumes the card model answers every frame it sees unless rsp_len is zero. */
`timescale 1ns/1ps
module smr_cmd_resp_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0, hwrite = 1'b0, write_active = 1'b0, fifo_word_req = 1'b0;
  reg block_sent = 1'b0, tok_go = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [2:0] hsize = 3'h2, tok = 3'h0;
  reg [135:0] rsp = 136'h0;
  reg [7:0] rsp_len = 8'd48;
  reg [47:0] dma_cnt = 48'h0, c0;
  integer n_fail = 0, check_count = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, card_clk, cmd_out, cmd_oe_n, cmd_line, dat0, dma_req;
  wire [47:0] frame;
  always #20 clk = ~clk;
  always @(posedge clk) dma_cnt <= dma_cnt + {47'h0, dma_req === 1'b1};
  smr_cmd_resp #(.DIV_HALF(4)) smr_cmd_resp_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .card_clk(card_clk), .cmd_in(cmd_line), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .dat0_in(dat0), .write_active(write_active), .fifo_word_req(fifo_word_req),
    .block_sent(block_sent), .dma_req(dma_req));
  smr_card smr_card_i (.card_clk(card_clk), .cmd_out(cmd_out), .cmd_oe_n(cmd_oe_n),
    .rsp(rsp), .rsp_len(rsp_len), .tok(tok), .tok_go(tok_go), .cmd_line(cmd_line),
    .dat0(dat0), .frame(frame));
  task summarize;
  begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  task check(input [47:0] got, input [47:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Protocol CRC7 over a frame's leading 40 bits, zero start value.
  function [6:0] crc7(input [39:0] d);
    integer m;
  begin
    crc7 = 7'h00;
    for (m = 39; m >= 0; m = m - 1)
      crc7 = {crc7[5:0], 1'b0} ^ ((d[m] ^ crc7[6]) ? 7'h09 : 7'h00);
  end
  endfunction
  task timeout;
  begin
    check(48'h0, 48'h1);
    summarize;
  end
  endtask
  task wait_ready;
    integer k;
  begin
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      k = k + 1;
      if (k > 50)
        timeout;
      @(posedge clk);
    end
  end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d, output [31:0] q);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
    check({47'h0, hresp}, 48'h0);
  end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    reg [31:0] q;
  begin
    bus(1'b1, a, d, q);
  end
  endtask
  task rd(input [31:0] a, input [31:0] e);
    reg [31:0] q;
  begin
    bus(1'b0, a, 32'h0, q);
    check({16'h0, q}, {16'h0, e});
  end
  endtask
  task wait_bit(input [4:0] b, input v);
    reg [31:0] q;
    integer k;
  begin
    k = 0;
    q = {32{~v}};
    while (q[b] !== v)
    begin
      k = k + 1;
      if (k > 2000)
        timeout;
      bus(1'b0, 32'h18, 32'h0, q);
    end
  end
  endtask
  task t_reset;
    integer n;
  begin
    for (n = 8; n < 64; n = n + 4)
      rd(n, 32'h0);
    rd(32'h4, 32'h0);
    $display("reset values done");
  end
  endtask
  task t_args;
  begin
    wr(32'h8, 32'hdead_ffff);
    wr(32'hc, 32'h0000_a5c3);
    rd(32'h8, 32'hffff);
    rd(32'hc, 32'ha5c3);
    wr(32'h24, 32'h1234);
    rd(32'h24, 32'h0);
    wr(32'h80, 32'h55);
    rd(32'h80, 32'h0);
    $display("argument access done");
  end
  endtask
  task t_short(input [1:0] fmt, input [5:0] idx, input [15:0] v, input [15:0] w4);
    reg [31:0] q;
    reg e;
  begin
    rsp = {88'h0, 2'b00, idx, v, ~v, v[7:0]};
    rsp_len = 8'd48;
    wr(32'h8, {16'h0, v});
    wr(32'hc, {16'h0, ~v});
    wr(32'h0, {21'h0, fmt, 3'h0, idx});
    wait_bit(5'd0, 1'b0);
    check(frame, {2'b01, idx, v, ~v, crc7({2'b01, idx, v, ~v}), 1'b1});
    e = (fmt == 2'h1) && (v[7:1] != crc7({2'b00, idx, v, ~v}));
    bus(1'b0, 32'h18, 32'h0, q);
    check({44'h0, q[3:0]}, {44'h0, e, 3'b010});
    rd(32'h10, {26'h0, idx});
    rd(32'h3c, {16'h0, v});
    rd(32'h38, {16'h0, ~v});
    bus(1'b0, 32'h34, 32'h0, q);
    check({40'h0, q[7:0]}, {40'h0, v[7:0]});
    rd(32'h30, {16'h0, w4});
    rd(32'h8, {16'h0, v});
    rd(32'hc, {16'h0, ~v});
    $display("short response done");
  end
  endtask
  task t_long;
    integer n;
  begin
    rsp = {8'h3f, 16'hc007, 16'hc006, 16'hc005, 16'hc004,
      16'hc003, 16'hc002, 16'hc001, 16'hc000};
    rsp_len = 8'd136;
    wr(32'h0, {21'h0, 2'h2, 3'h0, 6'h02});
    wait_bit(5'd0, 1'b0);
    rd(32'h10, 32'h3f);
    for (n = 0; n < 8; n = n + 1)
      rd(32'h20 + 4 * n, 32'hc000 + n);
    $display("long response done");
  end
  endtask
  task t_quiet;
    reg [31:0] q;
    reg [39:0] f;
  begin
    rsp_len = 8'd0;
    wr(32'h0, {21'h0, 2'h1, 3'h0, 6'h05});
    wait_bit(5'd0, 1'b0);
    bus(1'b0, 32'h18, 32'h0, q);
    check({44'h0, q[3:0]}, 48'h4);
    wr(32'h0, {21'h0, 2'h0, 3'h0, 6'h06});
    wait_bit(5'd0, 1'b0);
    bus(1'b0, 32'h18, 32'h0, q);
    check({44'h0, q[3:0]}, 48'h0);
    f = {2'b01, 6'h06, 32'h96e1691e};
    check(frame, {f, crc7(f), 1'b1});
    $display("no response done");
  end
  endtask
  task t_dma;
  begin
    c0 = dma_cnt;
    wr(32'h4, 32'h0);
    repeat (4) @(posedge clk);
    check(dma_cnt - c0, 48'h0);
    write_active <= 1'b1;
    wr(32'h4, 32'h1);
    repeat (4) @(posedge clk);
    check(dma_cnt - c0, 48'h1);
    fifo_word_req <= 1'b1;
    @(posedge clk);
    fifo_word_req <= 1'b0;
    repeat (2) @(posedge clk);
    check(dma_cnt - c0, 48'h2);
    write_active <= 1'b0;
    $display("dma trigger done");
  end
  endtask
  task t_token;
  begin
    tok = 3'b010;
    block_sent <= 1'b1;
    @(posedge clk);
    block_sent <= 1'b0;
    tok_go = 1'b1;
    wait_bit(5'd4, 1'b1);
    rd(32'h14, 32'h05);
    wr(32'h14, 32'hffff_ffff);
    rd(32'h14, 32'hff);
    tok_go = 1'b0;
    $display("crc token done");
  end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_args;
    t_short(2'h3, 6'h11, 16'h5a3c, 16'h0000);
    t_long;
    t_short(2'h1, 6'h2a, 16'h96e1, 16'hc004);
    t_dma;
    t_token;
    t_quiet;
    summarize;
  end
endmodule
